// ==== hw/timer_one.sv ====
// 16-bit timer/counter with prescaler, compare period reset and irq
// assumes one AHB-Lite master, i_sleep from the power controller
// How it works
// - count up 0000h..FFFFh, wrap is overflow
// - overflow latches flag; irq only when enabled
// - control bit 0 runs or stops counting
// - bit 1 picks Fosc/4 or external rising edges
// - bit 2 picks sync or unsync external
// - bits 5-4 prescale 1, 2, 4, 8
// - bit 3 crystal on, pins forced input
// - crystal and unsync count run in sleep
// - bit 7 picks 16-bit or byte access
// - low read buffers high; low write loads both
// - buffered high write keeps prescaler; low clears
// - compare code 1011 trigger zeroes, starts conversion
// - trigger reset never sets overflow flag
// - write beats coinciding trigger
// - compare value acts as period
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module timer_one
   import timer_one_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic        i_sleep,
   input  wire logic        i_crystal_in_pin,
   input  wire logic        i_external_count_pin,
   input  wire logic        i_adc_enabled,
   output logic             o_irq,
   output logic             o_adc_start,
   output logic             o_crystal_osc_on,
   output logic             o_osc_pins_takeover,
   output logic      [15:0] o_count_pair
);
   // ***********************************
   // state
   // ***********************************
   logic [7:0]            timer_one_control;
   logic [15:0]           count_pair;
   logic [7:0]            count_high_byte;
   logic [15:0]           compare_value_pair;
   logic [3:0]            compare_mode_code;
   logic [EVENT_BITS-1:0] irq_status;
   logic [EVENT_BITS-1:0] irq_enable;
   logic [2:0]            pre_cnt;
   logic [1:0]            div_cnt;
   logic                  sync_pend;
   logic                  wr_pend;
   logic [7:0]            wr_addr;
   logic [1:0]            pin_rise;

   logic [7:0]            next_control;
   logic [15:0]           next_count;
   logic [7:0]            next_high_buf;
   logic [15:0]           next_compare;
   logic [3:0]            next_mode;
   logic [EVENT_BITS-1:0] next_status;
   logic [EVENT_BITS-1:0] next_enable;
   logic [2:0]            next_pre;
   logic [1:0]            next_div;
   logic                  next_sync_pend;
   logic                  next_adc;
   logic                  next_wr_pend;
   logic [7:0]            next_wr_addr;
   logic [31:0]           next_hrdata;

   logic                  instr_en;
   logic                  edge_sel;
   logic                  ext_pulse;
   logic                  src_pulse;
   logic                  tick;
   logic [2:0]            pre_last;
   logic                  trig_hit;
   logic                  ovf_hit;
   logic                  wide;
   logic                  cnt_write;
   logic                  addr_ok;
   logic                  rd_low;
   logic [EVENT_BITS-1:0] clr_bits;
   logic [EVENT_BITS-1:0] events;

   pin_edge_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_pin   ({i_external_count_pin, i_crystal_in_pin}),
      .o_rise  (pin_rise)
   );

   // ***********************************
   // bus side
   // ***********************************
   assign wide    = timer_one_control[BIT_WIDE];
   assign addr_ok = i_hsel && i_hready && i_htrans[1];
   assign rd_low  = addr_ok && !i_hwrite && (i_haddr[7:0] == ADDR_COUNT_LOW);

   always_comb begin
      next_wr_pend = addr_ok && i_hwrite;
      next_wr_addr = addr_ok ? i_haddr[7:0] : wr_addr;
      next_hrdata  = 32'h0000_0000;
      if (addr_ok && !i_hwrite) begin
         unique case (i_haddr[7:0])
            ADDR_CONTROL:      next_hrdata[7:0] = timer_one_control & CONTROL_WMASK;
            ADDR_COUNT_LOW:    next_hrdata[7:0] = count_pair[7:0];
            ADDR_COUNT_HIGH:   next_hrdata[7:0] = wide ? count_high_byte : count_pair[15:8];
            ADDR_COMPARE:      next_hrdata[15:0] = compare_value_pair;
            ADDR_COMPARE_MODE: next_hrdata[3:0] = compare_mode_code;
            ADDR_IRQ_STATUS:   next_hrdata[EVENT_BITS-1:0] = irq_status;
            ADDR_IRQ_ENABLE:   next_hrdata[EVENT_BITS-1:0] = irq_enable;
            default:           next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_pend  <= 1'b0;
         wr_addr  <= 8'h00;
         o_hrdata <= 32'h0000_0000;
      end else begin
         wr_pend  <= next_wr_pend;
         wr_addr  <= next_wr_addr;
         o_hrdata <= next_hrdata;
      end
   end

   // zero wait states, always OKAY
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   // ***********************************
   // count path
   // ***********************************
   // instruction clock halts in sleep, crystal keeps running
   assign instr_en  = (div_cnt == 2'(INSTR_DIV - 1)) && !i_sleep;
   assign edge_sel  = timer_one_control[BIT_OSC_EN] ? pin_rise[PIN_IDX_CRYSTAL]
                                                    : pin_rise[PIN_IDX_EXTERNAL];
   // unsync edges still pass the pin synchroniser: single clock domain
   assign ext_pulse = timer_one_control[BIT_SYNC_DIS] ? edge_sel : (sync_pend && instr_en);
   assign src_pulse = timer_one_control[BIT_SOURCE] ? ext_pulse : instr_en;
   assign pre_last  = 3'((4'h1 << timer_one_control[BIT_PRE_HI:BIT_PRE_LO]) - 4'h1);
   assign tick      = timer_one_control[BIT_RUN] && src_pulse && (pre_cnt == pre_last);
   assign trig_hit  = (compare_mode_code == SPECIAL_EVENT_CODE) && tick
                      && (count_pair == compare_value_pair);
   assign cnt_write = wr_pend && ((wr_addr == ADDR_COUNT_LOW) || (wr_addr == ADDR_COUNT_HIGH && !wide));
   assign ovf_hit   = tick && (count_pair == COUNT_MAX) && !trig_hit && !cnt_write;
   assign clr_bits  = (wr_pend && wr_addr == ADDR_IRQ_CLEAR) ? i_hwdata[EVENT_BITS-1:0] : '0;

   always_comb begin
      next_div       = i_sleep ? div_cnt : (instr_en ? 2'b00 : 2'(div_cnt + 2'b01));
      next_sync_pend = timer_one_control[BIT_SOURCE] && !timer_one_control[BIT_SYNC_DIS]
                       && (edge_sel || (sync_pend && !instr_en));
      next_control   = timer_one_control;
      next_count     = count_pair;
      next_high_buf  = count_high_byte;
      next_compare   = compare_value_pair;
      next_mode      = compare_mode_code;
      next_enable    = irq_enable;
      next_pre       = pre_cnt;
      events         = '0;
      events[EV_OVERFLOW] = ovf_hit;
      events[EV_TRIGGER]  = trig_hit;
      next_adc       = trig_hit && i_adc_enabled;
      if (timer_one_control[BIT_RUN] && src_pulse) begin
         next_pre = tick ? 3'b000 : 3'(pre_cnt + 3'b001);
      end
      if (trig_hit) begin
         next_count = COUNT_ZERO;
      end else if (tick) begin
         next_count = 16'(count_pair + 16'h0001);
      end
      if (rd_low && wide) begin
         next_high_buf = count_pair[15:8];
      end
      if (wr_pend) begin
         unique case (wr_addr)
            ADDR_CONTROL:      next_control = i_hwdata[7:0] & CONTROL_WMASK;
            ADDR_COUNT_LOW: begin
               next_count = {wide ? count_high_byte : count_pair[15:8], i_hwdata[7:0]};
               next_pre   = 3'b000;
            end
            ADDR_COUNT_HIGH: begin
               if (wide) begin
                  next_high_buf = i_hwdata[7:0];
               end else begin
                  next_count = {i_hwdata[7:0], count_pair[7:0]};
                  next_pre   = 3'b000;
               end
            end
            ADDR_COMPARE:      next_compare = i_hwdata[15:0];
            ADDR_COMPARE_MODE: next_mode = i_hwdata[3:0];
            ADDR_IRQ_ENABLE:   next_enable = i_hwdata[EVENT_BITS-1:0];
            default:           next_pre = next_pre;
         endcase
      end
      next_status = (irq_status & ~clr_bits) | events;
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         timer_one_control  <= CONTROL_RESET;
         count_pair         <= COUNT_ZERO;
         count_high_byte    <= 8'h00;
         compare_value_pair <= COMPARE_RESET;
         compare_mode_code  <= MODE_RESET;
         irq_status         <= '0;
         irq_enable         <= '0;
         pre_cnt            <= 3'b000;
         div_cnt            <= 2'b00;
         sync_pend          <= 1'b0;
         o_adc_start        <= 1'b0;
      end else begin
         timer_one_control  <= next_control;
         count_pair         <= next_count;
         count_high_byte    <= next_high_buf;
         compare_value_pair <= next_compare;
         compare_mode_code  <= next_mode;
         irq_status         <= next_status;
         irq_enable         <= next_enable;
         pre_cnt            <= next_pre;
         div_cnt            <= next_div;
         sync_pend          <= next_sync_pend;
         o_adc_start        <= next_adc;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   assign o_irq               = |(irq_status & irq_enable);
   assign o_crystal_osc_on    = timer_one_control[BIT_OSC_EN];
   assign o_osc_pins_takeover = timer_one_control[BIT_OSC_EN];
   assign o_count_pair        = count_pair;

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   chk_wrap_zero: assert property (ovf_hit |=> count_pair == COUNT_ZERO)
      else $error("no wrap to zero after overflow");
   chk_flag_latch: assert property (ovf_hit |=> irq_status[EV_OVERFLOW] ##1 irq_status[EV_OVERFLOW]
                                    || $past(clr_bits[EV_OVERFLOW], 1) || clr_bits[EV_OVERFLOW])
      else $error("overflow flag not held");
   chk_irq_gate: assert property (irq_status[EV_OVERFLOW] && irq_enable[EV_OVERFLOW] |-> o_irq)
      else $error("enabled overflow without irq");
   chk_stop_hold: assert property (!timer_one_control[BIT_RUN] && !cnt_write |=> $stable(count_pair))
      else $error("counter moved while stopped");
   chk_instr_rate: assert property (tick && !timer_one_control[BIT_SOURCE] |=> !tick[*3])
      else $error("internal ticks closer than four cycles");
   chk_sync_sleep: assert property (i_sleep && !timer_one_control[BIT_SYNC_DIS] |-> !tick)
      else $error("synced count moved in sleep");
   chk_pre_clear: assert property (wr_pend && wr_addr == ADDR_COUNT_LOW |=> pre_cnt == 3'b000)
      else $error("low write left prescaler");
   chk_high_buffer: assert property (rd_low && wide |=> count_high_byte == $past(count_pair[15:8]))
      else $error("high byte not buffered on low read");
   chk_write_wins: assert property (trig_hit && wr_pend && wr_addr == ADDR_COUNT_LOW
                                    |=> count_pair[7:0] == $past(i_hwdata[7:0]))
      else $error("trigger beat software write");
   chk_trig_noflag: assert property (trig_hit && !irq_status[EV_OVERFLOW] |=> !irq_status[EV_OVERFLOW])
      else $error("trigger set overflow flag");
   chk_period_zero: assert property (trig_hit && !cnt_write |=> count_pair == COUNT_ZERO)
      else $error("period restart missing");
   chk_adc_gate: assert property (trig_hit && i_adc_enabled |=> o_adc_start)
      else $error("conversion start missing");

   cov_overflow: cover property (ovf_hit && irq_enable[EV_OVERFLOW]);
   cov_trigger:  cover property (trig_hit && i_adc_enabled);
   cov_unsync:   cover property (tick && i_sleep && timer_one_control[BIT_SYNC_DIS]);
   cov_internal: cover property (tick && !timer_one_control[BIT_SOURCE]);
   cov_wide_rw:  cover property (rd_low && wide ##[1:20] wr_pend && wr_addr == ADDR_COUNT_LOW);
endmodule // timer_one

// ==== hw/timer_one_pkg.sv ====
// constants shared by the 16-bit timer/counter and its pin synchroniser
// assumes a 32-bit AHB-Lite register bus and one system clock
package timer_one_pkg;
   // ***********************************
   // register map (byte addresses)
   // ***********************************
   localparam logic [7:0] ADDR_CONTROL      = 8'h00;
   localparam logic [7:0] ADDR_COUNT_LOW    = 8'h04;
   localparam logic [7:0] ADDR_COUNT_HIGH   = 8'h08;
   localparam logic [7:0] ADDR_COMPARE      = 8'h0C;
   localparam logic [7:0] ADDR_COMPARE_MODE = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLEAR    = 8'h18;
   localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h1C;
   // ***********************************
   // control fields
   // ***********************************
   localparam int         BIT_RUN        = 0;
   localparam int         BIT_SOURCE     = 1;
   localparam int         BIT_SYNC_DIS   = 2;
   localparam int         BIT_OSC_EN     = 3;
   localparam int         BIT_PRE_LO     = 4;
   localparam int         BIT_PRE_HI     = 5;
   localparam int         BIT_WIDE       = 7;
   localparam logic [7:0] CONTROL_WMASK  = 8'hBF;
   localparam logic [7:0] CONTROL_RESET  = 8'h00;
   // ***********************************
   // counter, compare and events
   // ***********************************
   localparam logic [15:0] COUNT_ZERO         = 16'h0000;
   localparam logic [15:0] COUNT_MAX          = 16'hFFFF;
   localparam logic [15:0] COMPARE_RESET      = 16'hFFFF;
   localparam logic [3:0]  MODE_RESET         = 4'h0;
   localparam logic [3:0]  SPECIAL_EVENT_CODE = 4'hB;
   localparam int          EVENT_BITS         = 2;
   localparam int          EV_OVERFLOW        = 0;
   localparam int          EV_TRIGGER         = 1;
   localparam int          INSTR_DIV          = 4;
   localparam int          PIN_IDX_CRYSTAL    = 0;
   localparam int          PIN_IDX_EXTERNAL   = 1;
endpackage

// ==== hw/pin_edge_sync.sv ====
// two-flop synchroniser and rising edge detector, one per pin
// assumes pins are asynchronous to i_clock and slower than half its rate
`timescale 1ns/10ps
module pin_edge_sync
   import timer_one_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input  wire logic             i_clock,
   input  wire logic             i_nrst,
   input  wire logic [WIDTH-1:0] i_pin,
   output logic      [WIDTH-1:0] o_rise
);
   // ***********************************
   // per pin
   // ***********************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_pin
         logic meta;
         logic stable;
         logic prev;
         logic rise;
         logic next_rise;
         always_comb begin
            next_rise = stable & ~prev;
         end
         // meta feeds only stable
         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               meta      <= 1'b0;
               stable    <= 1'b0;
               prev      <= 1'b0;
               rise      <= 1'b0;
            end else begin
               meta      <= i_pin[g];
               stable    <= meta;
               prev      <= stable;
               rise      <= next_rise;
            end
         end
         // one flop per bit, so no two processes share a variable
         assign o_rise[g] = rise;
      end
   endgenerate
endmodule // pin_edge_sync

// ==== tb/ext_clock_source.sv ====
// far-side model: external count pin and crystal, driven with the same edges
// assumes the caller starts send() just after a rising edge of i_clock
`timescale 1ns/10ps
module ext_clock_source #(
   parameter int HALF = 6
) (
   input  wire logic i_clock,
   output logic      o_crystal_in_pin,
   output logic      o_external_count_pin
);
   // ***********************************
   // burst of rising edges
   // ***********************************
   // both pins low between bursts: the source stands still outside a burst
   initial begin
      o_crystal_in_pin     = 1'b0;
      o_external_count_pin = 1'b0;
   end
   task automatic send(input int n);
      repeat (n) begin
         repeat (HALF) @(posedge i_clock);
         o_crystal_in_pin     <= 1'b1;
         o_external_count_pin <= 1'b1;
         repeat (HALF) @(posedge i_clock);
         o_crystal_in_pin     <= 1'b0;
         o_external_count_pin <= 1'b0;
      end
   endtask
endmodule // ext_clock_source

// ==== tb/timer_one_test.sv ====
// self-checking bench for the timer/counter over its AHB-Lite registers
// assumes the pin model ext_clock_source and the design package
`timescale 1ns/10ps
module timer_one_test;
   import timer_one_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_nrst  = 1'b0;
   logic        hsel    = 1'b1;
   logic        hwrite  = 1'b0;
   logic        sleep   = 1'b0;
   logic        adc_en  = 1'b1;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic [31:0] hrdata, q;
   logic        hreadyout, hresp, irq, adc_start, osc_on, takeover, xtal, extp;
   logic [15:0] count_pair;
   int          n_fail = 0, n_compared = 0, n_adc = 0, k;
   always #2 i_clock = ~i_clock;
   always @(posedge i_clock) if (adc_start === 1'b1) n_adc++;
   timer_one uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .i_sleep(sleep), .i_crystal_in_pin(xtal),
      .i_external_count_pin(extp), .i_adc_enabled(adc_en), .o_irq(irq), .o_adc_start(adc_start),
      .o_crystal_osc_on(osc_on), .o_osc_pins_takeover(takeover), .o_count_pair(count_pair));
   ext_clock_source #(.HALF(6)) ext (.i_clock(i_clock), .o_crystal_in_pin(xtal), .o_external_count_pin(extp));
   // ***********************************
   // bus and compare tasks
   // ***********************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one edge of idle first, so htrans is never assigned twice in a step
   // waits end only on ready or by the watchdog
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge i_clock);
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge i_clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do @(posedge i_clock); while (hreadyout !== 1'b1);
      q = hrdata;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input string what);
      bus(a, 1'b0, 32'h0);
      check(q, exp, what);
   endtask
   task automatic set_count(input logic [7:0] h, input logic [7:0] l);
      wr(ADDR_COUNT_HIGH, {24'h0, h});
      wr(ADDR_COUNT_LOW, {24'h0, l});
   endtask
   task automatic pulses(input int n);
      ext.send(n);
      repeat (20) @(posedge i_clock);
      #1;
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ***********************************
   // tests
   // ***********************************
   initial begin
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      read_check(ADDR_CONTROL, {24'h0, CONTROL_RESET}, "control reset");
      read_check(ADDR_COMPARE, {16'h0, COMPARE_RESET}, "compare reset");
      read_check(ADDR_IRQ_STATUS, 32'h0, "status reset");
      read_check(8'h40, 32'h0, "unmapped read");
      check({31'h0, hresp}, 32'h0, "okay response");
      wr(ADDR_CONTROL, 32'hFF);
      read_check(ADDR_CONTROL, 32'hBF, "control bit 6");
      check({31'h0, osc_on}, 32'h1, "osc on");
      check({31'h0, takeover}, 32'h1, "pins taken");
      wr(ADDR_CONTROL, 32'h0);
      check({31'h0, takeover}, 32'h0, "pins released");
      $display("test registers done");
      // unsynchronised external source, every prescale code
      for (k = 0; k < 4; k++) begin
         wr(ADDR_CONTROL, 32'h07 | (k << 4));
         set_count(8'h00, 8'h00);
         pulses(8);
         check({16'h0, count_pair}, 32'h8 >> k, "prescaled count");
      end
      wr(ADDR_CONTROL, 32'h06);
      pulses(3);
      check({16'h0, count_pair}, 32'h1, "stopped count");
      $display("test prescale done");
      wr(ADDR_CONTROL, 32'h07);
      set_count(8'hFF, 8'hFF);
      pulses(1);
      check({16'h0, count_pair}, 32'h0, "wrap");
      read_check(ADDR_IRQ_STATUS, 32'h1, "overflow flag");
      check({31'h0, irq}, 32'h0, "irq masked");
      wr(ADDR_IRQ_ENABLE, 32'h1);
      check({31'h0, irq}, 32'h1, "irq enabled");
      repeat (10) @(posedge i_clock);
      read_check(ADDR_IRQ_STATUS, 32'h1, "flag sticky");
      wr(ADDR_IRQ_CLEAR, 32'h1);
      check({31'h0, irq}, 32'h0, "irq cleared");
      read_check(ADDR_IRQ_STATUS, 32'h0, "flag cleared");
      $display("test overflow done");
      // synchronised source keeps the trigger reset dependable
      wr(ADDR_CONTROL, 32'h03);
      wr(ADDR_COMPARE, 32'h3);
      wr(ADDR_COMPARE_MODE, {28'h0, SPECIAL_EVENT_CODE});
      set_count(8'h00, 8'h00);
      pulses(6);
      check({16'h0, count_pair}, 32'h2, "period count");
      read_check(ADDR_IRQ_STATUS, 32'h2, "trigger no overflow");
      check(32'(n_adc), 32'h1, "conversion start");
      @(posedge i_clock) adc_en <= 1'b0;
      pulses(4);
      check({16'h0, count_pair}, 32'h2, "second period");
      check(32'(n_adc), 32'h1, "converter off");
      wr(ADDR_COMPARE_MODE, 32'h0);
      wr(ADDR_IRQ_CLEAR, 32'h3);
      $display("test trigger done");
      set_count(8'h00, 8'h00);
      @(posedge i_clock) sleep <= 1'b1;
      pulses(4);
      check({16'h0, count_pair}, 32'h0, "sync in sleep");
      wr(ADDR_CONTROL, 32'h07);
      pulses(4);
      check({16'h0, count_pair}, 32'h4, "unsync in sleep");
      @(posedge i_clock) sleep <= 1'b0;
      $display("test sleep done");
      wr(ADDR_CONTROL, 32'h80);
      wr(ADDR_COUNT_HIGH, 32'h12);
      check({16'h0, count_pair}, 32'h4, "buffered high");
      wr(ADDR_COUNT_LOW, 32'h34);
      check({16'h0, count_pair}, 32'h1234, "wide load");
      wr(ADDR_CONTROL, 32'h0);
      set_count(8'h56, 8'h78);
      check({16'h0, count_pair}, 32'h5678, "byte writes");
      wr(ADDR_CONTROL, 32'h80);
      read_check(ADDR_COUNT_LOW, 32'h78, "wide low");
      read_check(ADDR_COUNT_HIGH, 32'h56, "wide high");
      wr(ADDR_CONTROL, 32'h97);
      set_count(8'h00, 8'h00);
      pulses(1);
      wr(ADDR_COUNT_HIGH, 32'h0);
      pulses(1);
      check({16'h0, count_pair}, 32'h1, "prescaler kept");
      $display("test wide done");
      // 404 run edges hold exactly 404/4 instruction enables whatever the divider phase
      wr(ADDR_CONTROL, 32'h0);
      set_count(8'h00, 8'h00);
      wr(ADDR_CONTROL, 32'h01);
      repeat (401) @(posedge i_clock);
      wr(ADDR_CONTROL, 32'h0);
      check({16'h0, count_pair}, 32'(404 / INSTR_DIV), "internal rate");
      set_count(8'h00, 8'h00);
      wr(ADDR_CONTROL, 32'h0F);
      pulses(2);
      check({16'h0, count_pair}, 32'h2, "crystal count");
      $display("test internal done");
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      n_fail++;
      $display("ERROR t=%0t watchdog expired", $time);
      wrap_up();
   end
endmodule // timer_one_test
